// [fdis_pkg.sv]
// Purpose: Shared constants for the framer and data-link interrupt status block
// Assumes: AHB-Lite register bus, 8-bit registers in the low byte of each word
// Notes:   Offsets are byte addresses decoded on haddr[7:0]
package fdis_pkg;

    // Register geometry
    localparam int unsigned    FDIS_REG_W      = 8;
    localparam int unsigned    FDIS_DATA_W     = 32;
    localparam int unsigned    FDIS_ADDR_W     = 32;
    localparam int unsigned    FDIS_DEC_W      = 8;
    localparam int unsigned    FDIS_NFLAG      = 5;

    // Register offsets
    localparam logic [7:0]     OFF_FRAMER_IRQ_ENABLE  = 8'h00;
    localparam logic [7:0]     OFF_FRAMER_IRQ_STATUS  = 8'h04;
    localparam logic [7:0]     OFF_LINK_CTRL1_STATUS  = 8'h08;
    localparam logic [7:0]     OFF_LINK_CTRL1_ENABLE  = 8'h0C;

    // Reset values
    localparam logic [7:0]     REG_RESET       = 8'h00;
    localparam logic [31:0]    WORD_ZERO       = 32'h0000_0000;

    // Framer enable and status bit positions
    localparam int unsigned    BIT_CRC_ERROR   = 1;
    localparam int unsigned    BIT_FRAMING_ERR = 0;

    // Data-link status and enable bit positions
    localparam int unsigned    BIT_MSG_KIND    = 7;
    localparam int unsigned    BIT_TX_BEGIN    = 6;
    localparam int unsigned    BIT_RX_BEGIN    = 5;
    localparam int unsigned    BIT_TX_DONE     = 4;

    // Sticky flag indices
    localparam int unsigned    FLG_FE          = 0;
    localparam int unsigned    FLG_CRC         = 1;
    localparam int unsigned    FLG_TXD         = 2;
    localparam int unsigned    FLG_RXB         = 3;
    localparam int unsigned    FLG_TXB         = 4;

    // Message kind encoding
    localparam logic           KIND_BIT_ORIENTED = 1'b0;
    localparam logic           KIND_MSG_ORIENTED = 1'b1;

    // AHB-Lite encodings
    localparam logic [1:0]     HTRANS_NONSEQ   = 2'h2;
    localparam logic [2:0]     HSIZE_WORD      = 3'h2;
    localparam logic           HRESP_OKAY      = 1'b0;

    typedef enum logic [2:0] {
        SEL_NONE  = 3'b000,
        SEL_FRM_EN = 3'b001,
        SEL_FRM_ST = 3'b010,
        SEL_LNK_ST = 3'b011,
        SEL_LNK_EN = 3'b100
    } fdis_sel_t;

    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_WAIT = 1'b1
    } fdis_bus_st_t;

endpackage

// [fdis_flags.sv]
// Purpose: Sticky event flags, cleared on request
// Assumes: Set and clear come from logic on the same clock
// Notes:   A set in the clearing cycle keeps the flag high
`timescale 1ns/1ps
module fdis_flags #(
    parameter int unsigned W = 5
) (
    input  wire logic          clock,
    input  wire logic          rst_n,
    input  wire logic [W-1:0]  set,
    input  wire logic [W-1:0]  clear,
    output logic      [W-1:0]  flags
);

    typedef struct packed {
        logic [W-1:0] flags;
    } fdis_flags_st_t;

    fdis_flags_st_t s_q;
    fdis_flags_st_t s_d;

    always_comb begin
        s_d       = s_q;
        // Set wins over clear
        s_d.flags = set | (s_q.flags & ~clear);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flags = s_q.flags;

endmodule

// [fdis_top.sv]
// Purpose: Interrupt enables and read-to-clear status for framer errors and data-link events
// Assumes: Event inputs are one-cycle pulses from engines on the same clock
// Notes:   Every selected NONSEQ word transfer takes one wait state; other transfers are ignored and take none
//
// Local design decisions: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module fdis_top (
    input  wire logic         clock,
    input  wire logic         rst_n,
    // AHB-Lite slave
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic              hresp,
    output logic      [31:0]  hrdata,
    // Framer events
    input  wire logic         crc_error_evt,
    input  wire logic         framing_bit_error_evt,
    // Data-link events
    input  wire logic         tx_message_begin_evt,
    input  wire logic         rx_message_begin_evt,
    input  wire logic         tx_message_done_evt,
    input  wire logic         rx_message_kind_valid,
    input  wire logic         message_oriented_signaling,
    // Combined interrupt
    output logic              irq
);

    typedef struct packed {
        fdis_pkg::fdis_bus_st_t bus;
        fdis_pkg::fdis_sel_t    sel;
        logic                   wr;
        logic                   crc_error_irq_enable;
        logic                   framing_bit_error_irq_enable;
        logic                   tx_begin_irq_enable;
        logic                   rx_begin_irq_enable;
        logic                   tx_done_irq_enable;
        logic                   received_message_kind;
        logic [31:0]            hrdata;
        logic                   hready;
        logic                   irq;
    } fdis_st_t;

    localparam fdis_st_t ST_RESET = '{
        bus:                          fdis_pkg::BUS_IDLE,
        sel:                          fdis_pkg::SEL_NONE,
        wr:                           1'b0,
        crc_error_irq_enable:         1'b0,
        framing_bit_error_irq_enable: 1'b0,
        tx_begin_irq_enable:          1'b0,
        rx_begin_irq_enable:          1'b0,
        tx_done_irq_enable:           1'b0,
        received_message_kind:        fdis_pkg::KIND_BIT_ORIENTED,
        hrdata:                       fdis_pkg::WORD_ZERO,
        hready:                       1'b1,
        irq:                          1'b0
    };

    fdis_st_t                       s_q;
    fdis_st_t                       s_d;
    logic [fdis_pkg::FDIS_NFLAG-1:0] flag_set;
    logic [fdis_pkg::FDIS_NFLAG-1:0] flag_clr;
    logic [fdis_pkg::FDIS_NFLAG-1:0] flags;
    logic [fdis_pkg::FDIS_NFLAG-1:0] enables;
    logic [fdis_pkg::FDIS_NFLAG-1:0] masked;
    logic                           accept;

    function automatic fdis_pkg::fdis_sel_t decode_sel(input logic [7:0] a);
        fdis_pkg::fdis_sel_t r;
        r = fdis_pkg::SEL_NONE;
        if (a == fdis_pkg::OFF_FRAMER_IRQ_ENABLE) begin
            r = fdis_pkg::SEL_FRM_EN;
        end else if (a == fdis_pkg::OFF_FRAMER_IRQ_STATUS) begin
            r = fdis_pkg::SEL_FRM_ST;
        end else if (a == fdis_pkg::OFF_LINK_CTRL1_STATUS) begin
            r = fdis_pkg::SEL_LNK_ST;
        end else if (a == fdis_pkg::OFF_LINK_CTRL1_ENABLE) begin
            r = fdis_pkg::SEL_LNK_EN;
        end
        return r;
    endfunction

    function automatic logic [31:0] read_word(input fdis_pkg::fdis_sel_t sel, input fdis_st_t s,
                                              input logic [fdis_pkg::FDIS_NFLAG-1:0] f);
        logic [7:0] b;
        b = fdis_pkg::REG_RESET;
        unique case (sel)
            fdis_pkg::SEL_FRM_EN: begin
                b[fdis_pkg::BIT_CRC_ERROR]   = s.crc_error_irq_enable;
                b[fdis_pkg::BIT_FRAMING_ERR] = s.framing_bit_error_irq_enable;
            end
            fdis_pkg::SEL_FRM_ST: begin
                b[fdis_pkg::BIT_CRC_ERROR]   = f[fdis_pkg::FLG_CRC];
                b[fdis_pkg::BIT_FRAMING_ERR] = f[fdis_pkg::FLG_FE];
            end
            fdis_pkg::SEL_LNK_ST: begin
                b[fdis_pkg::BIT_MSG_KIND] = s.received_message_kind;
                b[fdis_pkg::BIT_TX_BEGIN] = f[fdis_pkg::FLG_TXB];
                b[fdis_pkg::BIT_RX_BEGIN] = f[fdis_pkg::FLG_RXB];
                b[fdis_pkg::BIT_TX_DONE]  = f[fdis_pkg::FLG_TXD];
            end
            fdis_pkg::SEL_LNK_EN: begin
                b[fdis_pkg::BIT_TX_BEGIN] = s.tx_begin_irq_enable;
                b[fdis_pkg::BIT_RX_BEGIN] = s.rx_begin_irq_enable;
                b[fdis_pkg::BIT_TX_DONE]  = s.tx_done_irq_enable;
            end
            fdis_pkg::SEL_NONE: begin
                b = fdis_pkg::REG_RESET;
            end
            default: begin
                b = fdis_pkg::REG_RESET;
            end
        endcase
        return {24'h00_0000, b};
    endfunction

    assign accept = hsel && hready && (htrans == fdis_pkg::HTRANS_NONSEQ) && (hsize == fdis_pkg::HSIZE_WORD);

    // Events map straight to flags, with no dependence on frame sync
    always_comb begin
        flag_set                     = '0;
        flag_set[fdis_pkg::FLG_CRC]  = crc_error_evt;
        flag_set[fdis_pkg::FLG_FE]   = framing_bit_error_evt;
        flag_set[fdis_pkg::FLG_TXB]  = tx_message_begin_evt;
        flag_set[fdis_pkg::FLG_RXB]  = rx_message_begin_evt;
        flag_set[fdis_pkg::FLG_TXD]  = tx_message_done_evt;
    end

    always_comb begin
        enables                     = '0;
        enables[fdis_pkg::FLG_CRC]  = s_q.crc_error_irq_enable;
        enables[fdis_pkg::FLG_FE]   = s_q.framing_bit_error_irq_enable;
        enables[fdis_pkg::FLG_TXB]  = s_q.tx_begin_irq_enable;
        enables[fdis_pkg::FLG_RXB]  = s_q.rx_begin_irq_enable;
        enables[fdis_pkg::FLG_TXD]  = s_q.tx_done_irq_enable;
        masked                      = flags & enables;
    end

    // Read of a status register clears its event flags
    always_comb begin
        flag_clr = '0;
        if (s_q.bus == fdis_pkg::BUS_WAIT && !s_q.wr) begin
            if (s_q.sel == fdis_pkg::SEL_FRM_ST) begin
                flag_clr[fdis_pkg::FLG_CRC] = 1'b1;
                flag_clr[fdis_pkg::FLG_FE]  = 1'b1;
            end
            if (s_q.sel == fdis_pkg::SEL_LNK_ST) begin
                flag_clr[fdis_pkg::FLG_TXB] = 1'b1;
                flag_clr[fdis_pkg::FLG_RXB] = 1'b1;
                flag_clr[fdis_pkg::FLG_TXD] = 1'b1;
            end
        end
    end

    fdis_flags #(
        .W(fdis_pkg::FDIS_NFLAG)
    ) u_flags (
        .clock (clock),
        .rst_n (rst_n),
        .set   (flag_set),
        .clear (flag_clr),
        .flags (flags)
    );

    always_comb begin
        s_d     = s_q;
        s_d.irq = |masked;
        if (rx_message_kind_valid) begin
            s_d.received_message_kind = message_oriented_signaling;
        end
        unique case (s_q.bus)
            fdis_pkg::BUS_IDLE: begin
                if (accept) begin
                    s_d.bus    = fdis_pkg::BUS_WAIT;
                    s_d.sel    = decode_sel(haddr[fdis_pkg::FDIS_DEC_W-1:0]);
                    s_d.wr     = hwrite;
                    s_d.hready = 1'b0;
                end
            end
            fdis_pkg::BUS_WAIT: begin
                s_d.bus    = fdis_pkg::BUS_IDLE;
                s_d.hready = 1'b1;
                if (s_q.wr) begin
                    s_d.hrdata = fdis_pkg::WORD_ZERO;
                    if (s_q.sel == fdis_pkg::SEL_FRM_EN) begin
                        s_d.crc_error_irq_enable         = hwdata[fdis_pkg::BIT_CRC_ERROR];
                        s_d.framing_bit_error_irq_enable = hwdata[fdis_pkg::BIT_FRAMING_ERR];
                    end
                    if (s_q.sel == fdis_pkg::SEL_LNK_EN) begin
                        s_d.tx_begin_irq_enable = hwdata[fdis_pkg::BIT_TX_BEGIN];
                        s_d.rx_begin_irq_enable = hwdata[fdis_pkg::BIT_RX_BEGIN];
                        s_d.tx_done_irq_enable  = hwdata[fdis_pkg::BIT_TX_DONE];
                    end
                end else begin
                    s_d.hrdata = read_word(s_q.sel, s_q, flags);
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_q <= ST_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign hreadyout = s_q.hready;
    assign hrdata    = s_q.hrdata;
    assign hresp     = fdis_pkg::HRESP_OKAY;
    assign irq       = s_q.irq;

    // Checks

    property p_crc_flag;
        @(posedge clock) disable iff (!rst_n)
        crc_error_evt |=> flags[fdis_pkg::FLG_CRC];
    endproperty
    a_crc_flag: assert property (p_crc_flag) else $error("crc event did not set flag");

    property p_crc_irq;
        @(posedge clock) disable iff (!rst_n)
        (crc_error_evt && s_q.crc_error_irq_enable && !(s_q.bus == fdis_pkg::BUS_WAIT && s_q.wr))
            |=> ##1 irq;
    endproperty
    a_crc_irq: assert property (p_crc_irq) else $error("enabled crc event gave no irq");

    property p_fe_irq;
        @(posedge clock) disable iff (!rst_n)
        (framing_bit_error_evt && s_q.framing_bit_error_irq_enable && !(s_q.bus == fdis_pkg::BUS_WAIT && s_q.wr))
            |=> ##1 irq;
    endproperty
    a_fe_irq: assert property (p_fe_irq) else $error("enabled framing event gave no irq");

    property p_fe_flag;
        @(posedge clock) disable iff (!rst_n)
        framing_bit_error_evt |=> flags[fdis_pkg::FLG_FE];
    endproperty
    a_fe_flag: assert property (p_fe_flag) else $error("framing event did not set flag");

    property p_kind_hold;
        @(posedge clock) disable iff (!rst_n)
        !rx_message_kind_valid |=> $stable(s_q.received_message_kind);
    endproperty
    a_kind_hold: assert property (p_kind_hold) else $error("message kind changed without strobe");

    property p_kind_load;
        @(posedge clock) disable iff (!rst_n)
        rx_message_kind_valid |=> s_q.received_message_kind == $past(message_oriented_signaling);
    endproperty
    a_kind_load: assert property (p_kind_load) else $error("message kind not loaded");

    property p_txb_flag;
        @(posedge clock) disable iff (!rst_n)
        tx_message_begin_evt |=> flags[fdis_pkg::FLG_TXB];
    endproperty
    a_txb_flag: assert property (p_txb_flag) else $error("tx begin did not set flag");

    property p_rxb_flag;
        @(posedge clock) disable iff (!rst_n)
        rx_message_begin_evt |=> flags[fdis_pkg::FLG_RXB];
    endproperty
    a_rxb_flag: assert property (p_rxb_flag) else $error("rx begin did not set flag");

    property p_txd_flag;
        @(posedge clock) disable iff (!rst_n)
        tx_message_done_evt |=> flags[fdis_pkg::FLG_TXD];
    endproperty
    a_txd_flag: assert property (p_txd_flag) else $error("tx done did not set flag");

    property p_read_clears;
        @(posedge clock) disable iff (!rst_n)
        (s_q.bus == fdis_pkg::BUS_WAIT && !s_q.wr && s_q.sel == fdis_pkg::SEL_LNK_ST
            && !tx_message_begin_evt && !rx_message_begin_evt && !tx_message_done_evt)
            |=> !flags[fdis_pkg::FLG_TXB] && !flags[fdis_pkg::FLG_RXB] && !flags[fdis_pkg::FLG_TXD]
                && hrdata[fdis_pkg::BIT_TX_BEGIN] == $past(flags[fdis_pkg::FLG_TXB]);
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("status read did not clear");

    property p_irq_match;
        @(posedge clock) disable iff (!rst_n)
        ##1 irq == $past(|masked);
    endproperty
    a_irq_match: assert property (p_irq_match) else $error("irq does not follow enabled flags");

    property p_bus_wait;
        @(posedge clock) disable iff (!rst_n)
        (accept && s_q.bus == fdis_pkg::BUS_IDLE) |=> !hreadyout ##1 hreadyout;
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("bus wait state not one cycle");

    property p_fstat_clears;
        @(posedge clock) disable iff (!rst_n)
        (s_q.bus == fdis_pkg::BUS_WAIT && !s_q.wr && s_q.sel == fdis_pkg::SEL_FRM_ST
            && !crc_error_evt && !framing_bit_error_evt)
            |=> !flags[fdis_pkg::FLG_CRC] && !flags[fdis_pkg::FLG_FE];
    endproperty
    a_fstat_clears: assert property (p_fstat_clears) else $error("framer status read did not clear");

    property p_irq_masked;
        @(posedge clock) disable iff (!rst_n)
        (!s_q.crc_error_irq_enable && !s_q.framing_bit_error_irq_enable && !s_q.tx_begin_irq_enable
            && !s_q.rx_begin_irq_enable && !s_q.tx_done_irq_enable) |=> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq raised with all enables off");

    property p_fen_hold;
        @(posedge clock) disable iff (!rst_n)
        !(s_q.bus == fdis_pkg::BUS_WAIT && s_q.wr)
            |=> $stable(s_q.crc_error_irq_enable) && $stable(s_q.framing_bit_error_irq_enable);
    endproperty
    a_fen_hold: assert property (p_fen_hold) else $error("framer enable changed without write");

    property p_len_hold;
        @(posedge clock) disable iff (!rst_n)
        !(s_q.bus == fdis_pkg::BUS_WAIT && s_q.wr)
            |=> $stable(s_q.tx_begin_irq_enable) && $stable(s_q.rx_begin_irq_enable)
                && $stable(s_q.tx_done_irq_enable);
    endproperty
    a_len_hold: assert property (p_len_hold) else $error("link enable changed without write");

    property p_kind_read;
        @(posedge clock) disable iff (!rst_n)
        (s_q.bus == fdis_pkg::BUS_WAIT && !s_q.wr && s_q.sel == fdis_pkg::SEL_LNK_ST)
            |=> hrdata[fdis_pkg::BIT_MSG_KIND] == $past(s_q.received_message_kind);
    endproperty
    a_kind_read: assert property (p_kind_read) else $error("status read lost message kind");

    property p_txb_irq;
        @(posedge clock) disable iff (!rst_n)
        (tx_message_begin_evt && s_q.tx_begin_irq_enable && !(s_q.bus == fdis_pkg::BUS_WAIT && s_q.wr))
            |=> ##1 irq;
    endproperty
    a_txb_irq: assert property (p_txb_irq) else $error("enabled tx begin gave no irq");

endmodule

// [framer_datalink_irq_status_bench.sv]
// Purpose: Self-checking bench for the framer and data-link interrupt status block
// Assumes: Single AHB-Lite master, hready tied to the slave's hreadyout
// Notes:   Table rows cover enable and event pairs; hand tests cover kind, reset, unmapped addresses and set-wins
`timescale 1ns/1ps
module framer_datalink_irq_status_bench;

    typedef struct packed {
        logic [4:0] ev;
        logic [7:0] framer_irq_enable;
        logic [7:0] dlie;
        logic [7:0] sa;
        logic [7:0] exp;
        logic       irq;
    } fdis_row_t;

    localparam int NROW = 8;
    localparam fdis_row_t ROWS [NROW] = '{
        '{5'h02, 8'h02, 8'h00, 8'h04, 8'h02, 1'h1},
        '{5'h02, 8'h01, 8'h00, 8'h04, 8'h02, 1'h0},
        '{5'h01, 8'h01, 8'h00, 8'h04, 8'h01, 1'h1},
        '{5'h01, 8'h02, 8'h00, 8'h04, 8'h01, 1'h0},
        '{5'h10, 8'h00, 8'h40, 8'h08, 8'h40, 1'h1},
        '{5'h08, 8'h00, 8'h20, 8'h08, 8'h20, 1'h1},
        '{5'h04, 8'h00, 8'h10, 8'h08, 8'h10, 1'h1},
        '{5'h04, 8'h00, 8'h60, 8'h08, 8'h10, 1'h0}
    };

    logic        clock;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire  logic  hready;
    logic        hresp;
    logic [31:0] hrdata;
    logic        crc_evt;
    logic        fe_evt;
    logic        txb_evt;
    logic        rxb_evt;
    logic        txd_evt;
    logic        kind_valid;
    logic        msg_kind_level;
    logic        irq;
    logic [31:0] rd;
    int          miscompares;
    int          check_count;

    fdis_top u_dut (
        .clock                      (clock),
        .rst_n                      (rst_n),
        .hsel                       (hsel),
        .haddr                      (haddr),
        .htrans                     (htrans),
        .hwrite                     (hwrite),
        .hsize                      (hsize),
        .hwdata                     (hwdata),
        .hready                     (hready),
        .hreadyout                  (hready),
        .hresp                      (hresp),
        .hrdata                     (hrdata),
        .crc_error_evt              (crc_evt),
        .framing_bit_error_evt      (fe_evt),
        .tx_message_begin_evt       (txb_evt),
        .rx_message_begin_evt       (rxb_evt),
        .tx_message_done_evt        (txd_evt),
        .rx_message_kind_valid      (kind_valid),
        .message_oriented_signaling (msg_kind_level),
        .irq                        (irq)
    );

    always #2.5 clock = ~clock;

    task automatic test_done();
        if (miscompares == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // One single transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [2:0] size,
                       input logic [31:0] wdata, output logic [31:0] rdata);
        int n;
        hsel   <= 1'h1;
        haddr  <= {24'h000000, addr};
        hwrite <= wr;
        hsize  <= size;
        htrans <= fdis_pkg::HTRANS_NONSEQ;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hready !== 1'h1 && n < 20);
        if (hready !== 1'h1) begin
            miscompares++;
            $display("wrong value at %0t: bus address phase ran out", $time);
            test_done();
        end
        htrans <= 2'h0;
        hwdata <= wdata;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hready !== 1'h1 && n < 20);
        rdata = hrdata;
        check_bit(hresp, fdis_pkg::HRESP_OKAY, "hresp");
        if (hready !== 1'h1) begin
            miscompares++;
            $display("wrong value at %0t: bus wait ran out", $time);
            test_done();
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        logic [31:0] dummy;
        bus(1'h1, addr, fdis_pkg::HSIZE_WORD, {24'hFFFFFF, data}, dummy);
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp, input string what);
        logic [31:0] got;
        bus(1'h0, addr, fdis_pkg::HSIZE_WORD, 32'h00000000, got);
        check_word(got, {24'h000000, exp}, what);
    endtask

    // Event pulses one cycle wide, indexed as the sticky flags
    task automatic fire(input logic [4:0] ev);
        fe_evt  <= ev[fdis_pkg::FLG_FE];
        crc_evt <= ev[fdis_pkg::FLG_CRC];
        txd_evt <= ev[fdis_pkg::FLG_TXD];
        rxb_evt <= ev[fdis_pkg::FLG_RXB];
        txb_evt <= ev[fdis_pkg::FLG_TXB];
        @(posedge clock);
        {fe_evt, crc_evt, txd_evt, rxb_evt, txb_evt} <= 5'h00;
        repeat (3) @(posedge clock);
    endtask

    task automatic settle_irq(input logic exp, input string what);
        repeat (2) @(posedge clock);
        check_bit(irq, exp, what);
    endtask

    task automatic kind(input logic m);
        msg_kind_level <= m;
        kind_valid <= 1'h1;
        @(posedge clock);
        kind_valid <= 1'h0;
        @(posedge clock);
    endtask

    task automatic do_reset();
        rst_n <= 1'h0;
        repeat (8) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
    endtask

    initial begin
        clock = 1'h0;
        rst_n = 1'h0;
        {hsel, hwrite, crc_evt, fe_evt, txb_evt, rxb_evt, txd_evt, kind_valid, msg_kind_level} = 9'h000;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hsize = fdis_pkg::HSIZE_WORD;
        hwdata = 32'h00000000;
        miscompares = 0;
        check_count = 0;
        do_reset();
        check_bit(irq, 1'h0, "irq after reset");
        for (int a = 0; a < 4; a++) begin
            rd_chk(8'(a * 4), 8'h00, "reset value");
        end
        wr(8'h00, 8'hFF);
        rd_chk(8'h00, 8'h03, "framer enable bits");
        wr(8'h0C, 8'hFF);
        rd_chk(8'h0C, 8'h70, "link enable bits");
        for (int i = 0; i < NROW; i++) begin
            wr(8'h00, ROWS[i].framer_irq_enable);
            wr(8'h0C, ROWS[i].dlie);
            fire(ROWS[i].ev);
            check_bit(irq, ROWS[i].irq, "irq on event");
            rd_chk(ROWS[i].sa, ROWS[i].exp, "status on event");
            rd_chk(ROWS[i].sa, 8'h00, "status after read");
            settle_irq(1'h0, "irq after clear");
        end
        // Message kind is sticky and read-only
        kind(fdis_pkg::KIND_MSG_ORIENTED);
        rd_chk(8'h08, 8'h80, "kind message oriented");
        wr(8'h08, 8'h00);
        rd_chk(8'h08, 8'h80, "kind survives read and write");
        kind(fdis_pkg::KIND_BIT_ORIENTED);
        rd_chk(8'h08, 8'h00, "kind bit oriented");
        // Two enabled sources; clearing one keeps irq up
        wr(8'h00, 8'h02);
        wr(8'h0C, 8'h40);
        fire(5'h12);
        rd_chk(8'h04, 8'h02, "framer status of pair");
        settle_irq(1'h1, "irq held by link flag");
        rd_chk(8'h08, 8'h40, "link status of pair");
        settle_irq(1'h0, "irq after both reads");
        // Host sees transmit start, refills, then sees transmit end
        fire(5'h10);
        rd_chk(8'h08, 8'h40, "transmit start seen by host");
        fire(5'h04);
        rd_chk(8'h08, 8'h10, "transmit end after refill");
        settle_irq(1'h0, "irq after transmit pair");
        // Event in the clearing cycle survives the read
        fork
            rd_chk(8'h04, 8'h00, "read racing event");
            begin
                @(posedge clock);
                crc_evt <= 1'h1;
                @(posedge clock);
                crc_evt <= 1'h0;
            end
        join
        rd_chk(8'h04, 8'h02, "flag set during read");
        // Unmapped and non-word accesses
        wr(8'h10, 8'hFF);
        rd_chk(8'h10, 8'h00, "unmapped read");
        bus(1'h1, 8'h00, 3'h0, 32'h00000000, rd);
        rd_chk(8'h00, 8'h02, "byte write ignored");
        bus(1'h0, 8'h00, fdis_pkg::HSIZE_WORD, 32'h00000000, rd);
        check_word(rd & 32'hFFFFFF00, 32'h00000000, "upper read bits");
        // Reset in mid-run drops flags, enables and irq
        fire(5'h03);
        settle_irq(1'h1, "irq before reset");
        do_reset();
        check_bit(irq, 1'h0, "irq after second reset");
        rd_chk(8'h00, 8'h00, "enable after second reset");
        rd_chk(8'h04, 8'h00, "status after second reset");
        test_done();
    end

endmodule
